//--- logic/serial_rx_decode_fifo.sv
// Contract
// [RULE1] decoding enabled: framed 10/12-bit characters become data or command codes
// [RULE2] special flag low for data, high for command codes
// [RULE3] decoding enabled: invalid or disparity-bad character raises violation flag
// [RULE4] bypass with byte width high: 10 raw bits forwarded unchanged
// [RULE5] bypass with byte width low: 12 raw bits forwarded unchanged
// [RULE6] self-test enable low: decoder output register runs 511-state LFSR
// [RULE7] once locked, compare each character, report errors on violation output
// [RULE8] generator starts at loop start code data 00, seen once per loop
// [RULE9] after loop start found, violation status marks each mismatch
// [RULE10] self-test ignores expected code and disparity violations
// [RULE11] self-test pulses fifo full one receive clock per loop
// [RULE12] too many compare errors: reset generator and search for start
// [RULE13] control runs on character clock; bypass drives it out on pin
// [RULE14] two-bit policy select; characters removed only with FIFO enabled
// [RULE15] policy 0 or bypass: every character passes on
// [RULE16] policy 1: runs of sync pairs keep only the last one
// [RULE17] policy 2: as policy 1, also drops C5.0 characters
// [RULE18] bypass: empty flag marks characters policy would drop; with policy 2 the code marks every sync character and no C5.0 character
// [RULE19] 256 x 14-bit FIFO, read by chip select with read enable
// [RULE20] UTOPIA flags and read enable active low, cascade active high; the code inverts empty and full only, half stays active high
// [RULE21] full, half and empty flags synchronous to receive char clock
// [RULE22] read controls sampled on each rising receive char clock
// [RULE23] sync code is eight-form with byte width high, ten-form otherwise
// [RULE24] half flag set while FIFO holds at least 128 characters
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_decode_fifo
  import rx_codec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] rx_char_in,
  input wire logic rx_char_strobe,
  input wire logic chip_select,
  input wire logic rx_read_enable,
  input wire logic rx_char_clock_i,
  output logic rx_char_clock_o,
  output logic rx_char_clock_oe,
  output logic [11:0] rx_data,
  output logic rx_special_char_flag,
  output logic violation_flag,
  output logic rx_violation_status,
  output logic rx_fifo_full,
  output logic rx_fifo_halfway,
  output logic rx_fifo_empty
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic dec_en;
    logic byte_w;
    logic st_n;
    logic [1:0] pol;
    logic byp_n;
    logic utopia;
    logic cs_s1;
    logic cs_s2;
    logic re_s1;
    logic re_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic [13:0] prev_word;
    logic prev_sync;
    logic prev_c50;
    logic prev_valid;
    st_state_t st;
    logic [8:0] lfsr;
    logic [3:0] err_cnt;
    logic loop_pend;
    logic [255:0][13:0] mem;
    logic [8:0] wptr;
    logic [8:0] rptr;
    logic [11:0] data;
    logic sc;
    logic vio;
    logic rvs;
    logic full;
    logic half;
    logic empty;
    logic clko;
    logic clkoe;
  } state_t;

  state_t s_q;
  state_t s_d;

  // returns {valid, command, code}
  function automatic logic [5:0] dec5(input logic [4:0] c);
    case (c)
      5'h1e: dec5 = 6'h20;
      5'h09: dec5 = 6'h21;
      5'h14: dec5 = 6'h22;
      5'h15: dec5 = 6'h23;
      5'h0a: dec5 = 6'h24;
      5'h0b: dec5 = 6'h25;
      5'h0e: dec5 = 6'h26;
      5'h0f: dec5 = 6'h27;
      5'h12: dec5 = 6'h28;
      5'h13: dec5 = 6'h29;
      5'h16: dec5 = 6'h2a;
      5'h17: dec5 = 6'h2b;
      5'h1a: dec5 = 6'h2c;
      5'h1b: dec5 = 6'h2d;
      5'h1c: dec5 = 6'h2e;
      5'h1d: dec5 = 6'h2f;
      5'h18: dec5 = 6'h30;
      5'h11: dec5 = 6'h31;
      5'h1f: dec5 = 6'h32;
      5'h04: dec5 = 6'h33;
      5'h00: dec5 = 6'h34;
      5'h07: dec5 = 6'h35;
      5'h19: dec5 = 6'h36;
      5'h0d: dec5 = 6'h37;
      default: dec5 = 6'h00;
    endcase
  endfunction

  // returns {valid, command, code}
  function automatic logic [6:0] dec6(input logic [5:0] c);
    dec6 = {(c != 6'h00) && (c != 6'h3f), c[0] == ^c[5:1], c[5:1]};
  endfunction

  always_comb begin
    logic bypass;
    logic ck_rise;
    logic emit;
    logic tick;
    logic [5:0] h5;
    logic [5:0] l5;
    logic [6:0] h6;
    logic [6:0] l6;
    logic [13:0] cur;
    logic cur_sync;
    logic cur_c50;
    logic [8:0] exp9;
    logic mism;
    logic drop;
    logic mark;
    logic rd_req;
    logic [8:0] cnt;
    logic [8:0] wnext;
    logic [8:0] rnext;
    logic acc;
    logic mapped;
    bypass = 1'b0;
    ck_rise = 1'b0;
    emit = 1'b0;
    tick = 1'b0;
    h5 = 6'h00;
    l5 = 6'h00;
    h6 = 7'h00;
    l6 = 7'h00;
    cur = 14'h0000;
    cur_sync = 1'b0;
    cur_c50 = 1'b0;
    exp9 = 9'h000;
    mism = 1'b0;
    drop = 1'b0;
    mark = 1'b0;
    rd_req = 1'b0;
    cnt = 9'h000;
    wnext = 9'h000;
    rnext = 9'h000;
    acc = 1'b0;
    mapped = 1'b0;
    s_d = s_q;

    s_d.cs_s1 = chip_select;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.re_s1 = rx_read_enable;
    s_d.re_s2 = s_q.re_s1;
    s_d.ck_s1 = rx_char_clock_i;
    s_d.ck_s2 = s_q.ck_s1;
    s_d.ck_s3 = s_q.ck_s2;
    bypass = ~s_q.byp_n;
    ck_rise = s_q.ck_s2 & ~s_q.ck_s3; // RULE22

    // character decode
    h5 = dec5(rx_char_in[9:5]);
    l5 = dec5(rx_char_in[4:0]);
    h6 = dec6(rx_char_in[11:6]);
    l6 = dec6(rx_char_in[5:0]);
    if (!s_q.dec_en) begin
      if (s_q.byte_w) begin
        cur = {4'h0, rx_char_in[9:0]}; // RULE4
      end else begin
        cur = {2'h0, rx_char_in}; // RULE5
      end
    end else if (s_q.byte_w) begin
      cur[11:0] = {4'h0, h5[3:0], l5[3:0]}; // RULE1
      cur[12] = h5[4]; // RULE2
      cur[13] = ~(h5[5] & l5[5] & (h5[4] == l5[4])); // RULE3
    end else begin
      cur[11:0] = {2'h0, h6[4:0], l6[4:0]}; // RULE1
      cur[12] = h6[5]; // RULE2
      cur[13] = ~(h6[6] & l6[6] & (h6[5] == l6[5])); // RULE3
    end
    if (s_q.byte_w) begin
      cur_sync = rx_char_in[9:0] == SYNC_EIGHT_CODE; // RULE23
    end else begin
      cur_sync = rx_char_in == SYNC_TEN_CODE; // RULE23
    end
    cur_c50 = cur[12] && (cur[11:0] == C50_CODE);

    // self-test generator and checker
    exp9 = s_q.lfsr - 9'h001;
    mism = {cur[12], cur[7:0]} != exp9;
    if (rx_char_strobe && !s_q.st_n) begin
      cur[13] = 1'b0; // RULE10
      case (s_q.st)
        ST_SEARCH: begin
          if ({cur[12], cur[7:0]} == 9'h000) begin
            s_d.st = ST_CHECK;
            s_d.lfsr = {LFSR_INIT[7:0], LFSR_INIT[8] ^ LFSR_INIT[4]}; // RULE8
            s_d.err_cnt = 4'h0;
          end
        end
        ST_CHECK: begin
          cur[13] = mism; // RULE7 RULE9
          s_d.lfsr = {s_q.lfsr[7:0], s_q.lfsr[8] ^ s_q.lfsr[4]}; // RULE6
          if (s_q.lfsr == LFSR_INIT) begin
            s_d.loop_pend = 1'b1; // RULE11
            s_d.err_cnt = 4'h0;
          end
          if (mism) begin
            s_d.err_cnt = s_d.err_cnt + 4'h1;
            if (s_d.err_cnt == ERR_LIMIT) begin
              s_d.st = ST_SEARCH; // RULE12
              s_d.lfsr = LFSR_INIT; // RULE12
              s_d.err_cnt = 4'h0;
            end
          end
        end
        default: begin
          s_d.st = ST_SEARCH;
          s_d.lfsr = LFSR_INIT;
        end
      endcase
    end

    // one-character hold decides the fate of the previous one
    emit = rx_char_strobe & s_q.prev_valid;
    drop = ((s_q.pol == 2'h1 || s_q.pol == 2'h2) && s_q.prev_sync && cur_sync) // RULE16
      || (s_q.pol == 2'h2 && s_q.prev_c50); // RULE17
    mark = (s_q.pol == 2'h1 && s_q.prev_sync && cur_sync) // RULE18
      || (s_q.pol == 2'h2 && s_q.prev_sync); // RULE18
    if (rx_char_strobe) begin
      s_d.prev_word = cur;
      s_d.prev_sync = cur_sync;
      s_d.prev_c50 = cur_c50;
      s_d.prev_valid = 1'b1;
    end

    // receive FIFO
    cnt = s_q.wptr - s_q.rptr;
    wnext = s_q.wptr + 9'h001;
    rnext = s_q.rptr + 9'h001;
    if (!bypass && emit && !drop && cnt != FIFO_FULL_CNT) begin // RULE14 RULE15
      s_d.mem[s_q.wptr[7:0]] = s_q.prev_word; // RULE19
      s_d.wptr = wnext;
    end
    rd_req = s_q.cs_s2 && (s_q.re_s2 ^ s_q.utopia); // RULE19 RULE20

    tick = bypass ? emit : ck_rise; // RULE13
    s_d.clkoe = bypass;
    s_d.clko = bypass & emit; // RULE13
    if (tick) begin
      if (bypass) begin
        s_d.data = s_q.prev_word[11:0]; // RULE15
        s_d.sc = s_q.prev_word[12];
        s_d.vio = s_q.prev_word[13];
        s_d.rvs = s_q.prev_word[13] & ~s_q.st_n;
        s_d.empty = mark ^ s_q.utopia; // RULE18 RULE20
        s_d.full = s_q.utopia;
        s_d.half = 1'b0;
      end else begin
        if (rd_req && cnt != 9'h000) begin
          s_d.data = s_q.mem[s_q.rptr[7:0]][11:0];
          s_d.sc = s_q.mem[s_q.rptr[7:0]][12];
          s_d.vio = s_q.mem[s_q.rptr[7:0]][13];
          s_d.rvs = s_q.mem[s_q.rptr[7:0]][13] & ~s_q.st_n;
          s_d.rptr = rnext;
        end
        s_d.empty = (cnt == 9'h000) ^ s_q.utopia; // RULE20 RULE21
        s_d.full = (cnt == FIFO_FULL_CNT) ^ s_q.utopia; // RULE21
        s_d.half = cnt >= FIFO_HALF_CNT; // RULE24
      end
      if (!s_q.st_n) begin
        s_d.full = (s_q.loop_pend | s_d.loop_pend) ^ s_q.utopia; // RULE11
      end
      // cleared after use, so a loop end in this tick still shows
      s_d.loop_pend = 1'b0;
    end

    // APB slave, one wait state
    mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS);
    acc = psel & penable & ~s_q.pready;
    s_d.pready = acc;
    s_d.pslverr = acc & ~mapped;
    if (acc) begin
      s_d.prdata = 32'h00000000;
      if (paddr == CTRL_OFS) begin
        s_d.prdata[CTRL_DEC_EN] = s_q.dec_en;
        s_d.prdata[CTRL_BYTE_W] = s_q.byte_w;
        s_d.prdata[CTRL_ST_N] = s_q.st_n;
        s_d.prdata[CTRL_POL_LO +: 2] = s_q.pol;
        s_d.prdata[CTRL_BYP_N] = s_q.byp_n;
        s_d.prdata[CTRL_UTOPIA] = s_q.utopia;
      end else if (paddr == STATUS_OFS) begin
        s_d.prdata[8:0] = cnt;
        s_d.prdata[STAT_LOCK] = s_q.st == ST_CHECK;
        s_d.prdata[STAT_ERR_LO +: 4] = s_q.err_cnt;
      end
    end
    if (psel && penable && pwrite && s_q.pready && paddr == CTRL_OFS) begin
      s_d.dec_en = pwdata[CTRL_DEC_EN];
      s_d.byte_w = pwdata[CTRL_BYTE_W];
      s_d.st_n = pwdata[CTRL_ST_N];
      s_d.pol = pwdata[CTRL_POL_LO +: 2]; // RULE14
      s_d.byp_n = pwdata[CTRL_BYP_N];
      s_d.utopia = pwdata[CTRL_UTOPIA];
      if (pwdata[CTRL_ST_N]) begin
        s_d.st = ST_SEARCH;
        s_d.lfsr = LFSR_INIT;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.dec_en <= CTRL_DEC_EN_RST;
      s_q.byte_w <= CTRL_BYTE_W_RST;
      s_q.st_n <= CTRL_ST_N_RST;
      s_q.pol <= CTRL_POL_RST;
      s_q.byp_n <= CTRL_BYP_N_RST;
      s_q.utopia <= CTRL_UTOPIA_RST;
      s_q.st <= ST_SEARCH;
      s_q.lfsr <= LFSR_INIT;
      s_q.empty <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign rx_char_clock_o = s_q.clko;
  assign rx_char_clock_oe = s_q.clkoe;
  assign rx_data = s_q.data;
  assign rx_special_char_flag = s_q.sc;
  assign violation_flag = s_q.vio;
  assign rx_violation_status = s_q.rvs;
  assign rx_fifo_full = s_q.full;
  assign rx_fifo_halfway = s_q.half;
  assign rx_fifo_empty = s_q.empty;

endmodule
`default_nettype wire

//--- logic/rx_codec_pkg.sv
package rx_codec_pkg;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int CTRL_DEC_EN = 0;
  localparam int CTRL_BYTE_W = 1;
  localparam int CTRL_ST_N = 2;
  localparam int CTRL_POL_LO = 3;
  localparam int CTRL_BYP_N = 5;
  localparam int CTRL_UTOPIA = 6;
  localparam logic CTRL_DEC_EN_RST = 1'b1;
  localparam logic CTRL_BYTE_W_RST = 1'b1;
  localparam logic CTRL_ST_N_RST = 1'b1;
  localparam logic [1:0] CTRL_POL_RST = 2'h0;
  localparam logic CTRL_BYP_N_RST = 1'b1;
  localparam logic CTRL_UTOPIA_RST = 1'b0;
  localparam int STAT_LOCK = 9;
  localparam int STAT_ERR_LO = 12;
  localparam logic [8:0] FIFO_FULL_CNT = 9'h100;
  localparam logic [8:0] FIFO_HALF_CNT = 9'h080;
  localparam logic [9:0] SYNC_EIGHT_CODE = 10'h311;
  localparam logic [11:0] SYNC_TEN_CODE = 12'hc71;
  localparam logic [11:0] C50_CODE = 12'h028;
  localparam logic [8:0] LFSR_INIT = 9'h001;
  localparam logic [3:0] ERR_LIMIT = 4'h8;
  typedef enum logic [1:0] {
    ST_SEARCH = 2'b01,
    ST_CHECK = 2'b10
  } st_state_t;
endpackage

//--- tb/rx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rx_checker
  import rx_codec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] rx_char_in,
  input wire logic rx_char_strobe,
  input wire logic rx_char_clock_o,
  input wire logic rx_char_clock_oe,
  input wire logic [11:0] rx_data,
  input wire logic rx_fifo_empty
);
  logic [6:0] ctrl_q;
  logic [9:0] last_q;
  logic [9:0] prev_q;
  logic held_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 7'h27;
      last_q <= 10'h000;
      prev_q <= 10'h000;
      held_q <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS)
        ctrl_q <= pwdata[6:0];
      if (rx_char_strobe) begin
        last_q <= rx_char_in[9:0];
        prev_q <= last_q;
        held_q <= 1'b1;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr_ctrl; psel && penable && pready && pwrite && paddr == CTRL_OFS; endsequence
  sequence s_emit; rx_char_clock_o; endsequence
  property p_wait; s_setup |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");
  property p_err; psel && penable && pready && paddr > STATUS_OFS |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_oe; s_wr_ctrl |=> ##[0:3] (rx_char_clock_oe == !ctrl_q[5]); endproperty
  a_oe: assert property (p_oe) else $error("clock pin direction wrong");
  property p_pulse; s_emit |=> !rx_char_clock_o; endproperty
  a_pulse: assert property (p_pulse) else $error("output clock pulse too long");
  property p_cause; s_emit |-> rx_char_clock_oe && $past(rx_char_strobe); endproperty
  a_cause: assert property (p_cause) else $error("output clock without character");
  property p_nodrop; rx_char_strobe && held_q && rx_char_clock_oe |=> s_emit; endproperty
  a_nodrop: assert property (p_nodrop) else $error("bypass dropped a character");
  property p_raw; s_emit and ctrl_q[1:0] == 2'h2 |-> rx_data[9:0] == prev_q; endproperty
  a_raw: assert property (p_raw) else $error("raw character altered");
  property p_pol0; s_emit and ctrl_q[4:3] == 2'h0 && !ctrl_q[6] |-> !rx_fifo_empty; endproperty
  a_pol0: assert property (p_pol0) else $error("policy 0 marked invalid");
  property p_pol2;
    s_emit and ctrl_q[4:3] == 2'h2 && !ctrl_q[6] && prev_q == SYNC_EIGHT_CODE |-> rx_fifo_empty;
  endproperty
  a_pol2: assert property (p_pol2) else $error("policy 2 sync not marked");
endmodule
`default_nettype wire

//--- tb/rx_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module rx_far_end (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] n,
  output logic rclk,
  output logic cs,
  output logic ren,
  output logic done
);
  integer k;
  initial begin
    rclk = 1'b0;
    cs = 1'b0;
    ren = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        for (k = 0; k < n; k++) begin
          cs <= 1'b1;
          ren <= 1'b1;
          @(posedge pclk);
          rclk <= 1'b1;
          repeat (3) @(posedge pclk);
          rclk <= 1'b0;
          repeat (2) @(posedge pclk);
          done <= 1'b1;
          @(posedge pclk);
          done <= 1'b0;
          repeat (k % 3) @(posedge pclk);
        end
        cs <= 1'b0;
        ren <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rx_codec_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rx_char_strobe = 1'b0, go = 1'b0, have = 1'b0, byp = 1'b0, er, d;
  logic [11:0] paddr = 12'h000, rx_char_in = 12'h000, rx_data;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic cs, ren, rclk, clk_o, oe, pready, pslverr, sc, vf, vs, full, half, empty, done;
  logic [10:0] e;
  logic [9:0] prev;
  logic [7:0] n = 8'h00;
  logic [1:0] pol = 2'h0;
  integer fails = 0;
  integer compares = 0;
  integer seed = 32'h6632;
  integer kept, p;
  logic [10:0] exp_q[$];
  always #2.5 pclk = ~pclk;
  serial_rx_decode_fifo dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_char_in(rx_char_in),
    .rx_char_strobe(rx_char_strobe), .chip_select(cs), .rx_read_enable(ren),
    .rx_char_clock_i(rclk), .rx_char_clock_o(clk_o), .rx_char_clock_oe(oe), .rx_data(rx_data),
    .rx_special_char_flag(sc), .violation_flag(vf), .rx_violation_status(vs),
    .rx_fifo_full(full), .rx_fifo_halfway(half), .rx_fifo_empty(empty));
  rx_far_end far (.pclk(pclk), .go(go), .n(n), .rclk(rclk), .cs(cs), .ren(ren), .done(done));
  task check(input logic [31:0] seen, input logic [31:0] expv, input string what);
    compares++;
    if (seen !== expv) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task hang;
    fails++;
    complete_run();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    integer t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20)
      hang();
  endtask
  task wait_q(input integer s);
    integer t;
    t = 0;
    while (exp_q.size() > s && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 3000)
      hang();
  endtask
  task send_rand;
    logic [9:0] c;
    r = $random(seed);
    c = r[2] ? SYNC_EIGHT_CODE : {1'b0, r[11:3]};
    if (have) begin
      d = prev == SYNC_EIGHT_CODE && (pol == 2'h1 || pol == 2'h2) &&
          (c == SYNC_EIGHT_CODE || (byp && pol == 2'h2));
      if (byp)
        exp_q.push_back({d, prev});
      else if (!d)
        exp_q.push_back({1'b0, prev});
      if (!byp && !d)
        kept++;
    end
    prev = c;
    have = 1'b1;
    put({2'b00, c});
    if (r[0])
      @(posedge pclk);
  endtask
  task put(input logic [11:0] ch);
    @(posedge pclk);
    rx_char_in <= ch;
    rx_char_strobe <= 1'b1;
    @(posedge pclk);
    rx_char_strobe <= 1'b0;
  endtask
  task read(input logic [7:0] k, input integer left);
    @(posedge pclk);
    go <= 1'b1;
    n <= k;
    @(posedge pclk);
    go <= 1'b0;
    wait_q(left);
  endtask
  always @(negedge pclk) begin
    if (clk_o === 1'b1 || done === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 11'h7ff;
      check(rx_data[9:0], e[9:0], "rx_data");
      if (clk_o === 1'b1)
        check(empty, e[10], "valid_mark");
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h27, "ctrl_reset");
    apb(1'b0, 12'h008, 32'h0);
    check(er, 1'b1, "unmapped_err");
    check(rd, 32'h0, "unmapped_data");
    pol = 2'h1;
    apb(1'b1, CTRL_OFS, 32'h2e);
    kept = 0;
    while (kept < 128)
      send_rand();
    read(8'd1, 127);
    check(half, 1'b1, "halfway");
    check(empty, 1'b0, "empty");
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[8:0], 9'd127, "fifo_count");
    read(8'd127, 0);
    check(half, 1'b0, "half_clear");
    byp = 1'b1;
    for (p = 0; p < 4; p++) begin
      pol = p[1:0];
      apb(1'b1, CTRL_OFS, 32'h6 | (p << 3));
      repeat (4) @(posedge pclk);
      check(oe, 1'b1, "clock_dir");
      repeat (12) send_rand();
      wait_q(0);
    end
    apb(1'b1, CTRL_OFS, 32'h3); // decode, self-test, bypass
    exp_q.push_back({1'b0, prev});
    put(12'h3de); // loop start, data 00
    exp_q.push_back(11'h000);
    put(12'h3c9); // data 01, as the generator expects
    exp_q.push_back(11'h001);
    put(12'h3c9); // data 03 expected: mismatch
    exp_q.push_back(11'h001);
    put(12'h311);
    @(negedge pclk);
    check({full, sc, vf, vs}, 4'b0011, "selftest_error");
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[15:9], 7'h11, "selftest_lock");
    apb(1'b1, CTRL_OFS, 32'h7); // self-test off
    exp_q.push_back(11'h001);
    put(12'h021); // invalid symbol pair
    @(negedge pclk);
    check({sc, vf}, 2'b11, "command_flag");
    apb(1'b1, CTRL_OFS, 32'h4); // raw 12-bit
    exp_q.push_back(11'h000);
    put(12'hab5);
    @(negedge pclk);
    check({sc, vf, vs}, 3'b010, "invalid_code");
    exp_q.push_back(11'h2b5);
    put(12'hc71);
    @(negedge pclk);
    check(rx_data, 12'hab5, "raw_twelve");
    apb(1'b1, CTRL_OFS, 32'h14); // policy 2, ten-form sync
    exp_q.push_back(11'h471);
    put(12'h000);
    apb(1'b1, CTRL_OFS, 32'h54); // flags active low
    exp_q.push_back(11'h400);
    put(12'h000);
    @(negedge pclk);
    check(full, 1'b1, "utopia_full");
    wait_q(0);
    complete_run();
  end
endmodule
bind serial_rx_decode_fifo rx_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rx_char_in(rx_char_in), .rx_char_strobe(rx_char_strobe),
  .rx_char_clock_o(rx_char_clock_o), .rx_char_clock_oe(rx_char_clock_oe),
  .rx_data(rx_data), .rx_fifo_empty(rx_fifo_empty));
`default_nettype wire
